// File: hw/ssu_buf.sv
// Two-entry byte buffer with valid and ready on both sides.
`timescale 1ns/1ps
module ssu_buf (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data
);
	logic [7:0] mem [0:1];
	logic [1:0] count;
	logic wr_ptr;
	logic rd_ptr;
	logic push;
	logic pop;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mem[0] <= 8'h00;
			mem[1] <= 8'h00;
			wr_ptr <= 1'b0;
		end else if (push) begin
			mem[wr_ptr] <= in_data;
			wr_ptr <= ~wr_ptr;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_ptr <= 1'b0;
		end else if (pop) begin
			rd_ptr <= ~rd_ptr;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 2'h0;
		end else if (push && !pop) begin
			count <= count + 2'h1;
		end else if (pop && !push) begin
			count <= count - 2'h1;
		end
	end
endmodule : ssu_buf

// File: hw/ssu_defs.svh
// Constants for the synchronous serial unit.
//
// Behaviour
// - Full-duplex master or slave, three or four wire.
// - MOSI driven as master, input as slave.
// - Master shifts out MSB first from top bit.
// - MISO sampled as master, driven MSB first as slave.
// - MISO released when disabled or unselected four-wire slave.
// - Three-wire slave always drives MISO from top bit.
// - Master makes SCK; slave takes SCK in.
// - Unselected four-wire slave ignores all SCK edges.
// - Mode 00: three-wire, slave always selected.
// - Mode 01: select input decides slave selection.
// - Mode 01 master: select falling disables master.
// - Mode 1x: select is output at bit0 level.
// - Select pin unrouted in three-wire mode only.
// - Master sets done flag at byte end, interrupt.
// - Mode fault clears enables, sets fault flag.
// - Four-wire slave bit counter resets on select fall.
`ifndef SSU_DEFS_SVH
`define SSU_DEFS_SVH

`define SSU_MODE_3WIRE 2'h0
`define SSU_MODE_4WIRE_IN 2'h1
`define SSU_MODE_OUT_BIT 1
`define SSU_BYTE_BITS 8
`define SSU_LAST_BIT 4'h7
`define SSU_CLK_NS 40
`define SSU_SCK_HALF_NS 160
`define SSU_SCK_HALF_CYC \
	((`SSU_SCK_HALF_NS + `SSU_CLK_NS - 1) / `SSU_CLK_NS)
`define SSU_PIN_SCK 0
`define SSU_PIN_MOSI 1
`define SSU_PIN_MISO 2
`define SSU_PIN_SEL 3
`define SSU_PIN_RESET 4'h8

`endif

// File: hw/ssu_pkg.sv
// Types shared by the synchronous serial unit.
package ssu_pkg;
	typedef struct packed {
		logic out;
		logic oe;
	} ssu_pin_t;

	typedef struct packed {
		logic done;
		logic fault;
		logic overrun;
	} ssu_flags_t;

	typedef enum logic [0:0] {
		SSU_IDLE = 1'b0,
		SSU_RUN = 1'b1
	} ssu_state_t;
endpackage : ssu_pkg

// File: hw/ssu_top.sv
// Pin and select-mode logic of the synchronous serial unit.
`timescale 1ns/1ps
`include "ssu_defs.svh"
module ssu_top (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [1:0] select_pin_mode,
	input wire logic ctl_write,
	input wire logic ctl_port_enable,
	input wire logic ctl_master_enable,
	input wire logic int_enable,
	input wire ssu_pkg::ssu_flags_t flag_clear,
	output logic port_enable,
	output logic master_enable_flag,
	output ssu_pkg::ssu_flags_t flags,
	output logic irq,
	output logic select_routed,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	input wire logic sck_in,
	output ssu_pkg::ssu_pin_t sck_drv,
	input wire logic mosi_in,
	output ssu_pkg::ssu_pin_t mosi_drv,
	input wire logic miso_in,
	output ssu_pkg::ssu_pin_t miso_drv,
	input wire logic slave_select_in,
	output ssu_pkg::ssu_pin_t slave_select_drv
);
	localparam logic [7:0] HALF_CYC = 8'(`SSU_SCK_HALF_CYC);

	function automatic logic fell(input logic now, input logic was);
		fell = was && !now;
	endfunction : fell

	function automatic logic rose(input logic now, input logic was);
		rose = now && !was;
	endfunction : rose

	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] sync3;
	logic [3:0] pin_f;
	logic [3:0] pin_d;
	ssu_pkg::ssu_state_t state;
	logic [7:0] div_cnt;
	logic sck_out;
	logic [7:0] shreg;
	logic sample;
	logic pend;
	logic loaded;
	logic [3:0] bit_cnt;
	logic tb_valid;
	logic [7:0] tb_data;
	logic tb_pop;
	logic rb_ready;
	logic selected;
	logic slave_act;
	logic master_run;
	logic half_tick;
	logic rise_ev;
	logic fall_ev;
	logic in_bit;
	logic byte_done;
	logic sel_fall;
	logic fault_ev;
	logic start;
	logic [7:0] rx_byte;

	ssu_buf u_tx_buf (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(tb_valid),
		.out_ready(tb_pop),
		.out_data(tb_data)
	);

	ssu_buf u_rx_buf (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_valid(byte_done),
		.in_ready(rb_ready),
		.in_data(rx_byte),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	// Pins from outside pass three flops; a level counts once 2 and 3 agree.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1 <= `SSU_PIN_RESET;
			sync2 <= `SSU_PIN_RESET;
			sync3 <= `SSU_PIN_RESET;
		end else begin
			sync1 <= {slave_select_in, miso_in, mosi_in, sck_in};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_f <= `SSU_PIN_RESET;
			pin_d <= `SSU_PIN_RESET;
		end else begin
			pin_f <= (sync2 & sync3) | (pin_f & (sync2 ^ sync3));
			pin_d <= pin_f;
		end
	end

	// Mode 00 is always selected, mode 01 follows the select pin.
	always_comb begin
		if (select_pin_mode == `SSU_MODE_4WIRE_IN) begin
			selected = !pin_f[`SSU_PIN_SEL];
		end else begin
			selected = 1'b1;
		end
	end

	assign slave_act = port_enable && !master_enable_flag && selected;
	assign master_run = (state == ssu_pkg::SSU_RUN);
	assign sel_fall = fell(pin_f[`SSU_PIN_SEL], pin_d[`SSU_PIN_SEL]);
	assign fault_ev = port_enable && master_enable_flag &&
		(select_pin_mode == `SSU_MODE_4WIRE_IN) && sel_fall;
	assign half_tick = master_run && (div_cnt == HALF_CYC - 8'h01);

	always_comb begin
		if (master_run) begin
			rise_ev = half_tick && !sck_out;
			fall_ev = half_tick && sck_out;
			in_bit = pin_f[`SSU_PIN_MISO];
		end else begin
			rise_ev = slave_act &&
				rose(pin_f[`SSU_PIN_SCK], pin_d[`SSU_PIN_SCK]);
			fall_ev = slave_act &&
				fell(pin_f[`SSU_PIN_SCK], pin_d[`SSU_PIN_SCK]);
			in_bit = pin_f[`SSU_PIN_MOSI];
		end
	end

	// The pin path is as long as a half period, so the master takes MISO
	// at the end of the high phase, where the bit has surely arrived.
	assign byte_done = master_run ?
		(fall_ev && bit_cnt == 4'(`SSU_BYTE_BITS)) :
		(rise_ev && bit_cnt == `SSU_LAST_BIT);
	assign rx_byte = {shreg[6:0], in_bit};
	assign start = (state == ssu_pkg::SSU_IDLE) && port_enable &&
		master_enable_flag && tb_valid && rb_ready && !fault_ev;
	assign tb_pop = start || (slave_act && !loaded && !pend &&
		bit_cnt == 4'h0 && tb_valid);

	// Software writes the enables; a mode fault overrides the write.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			port_enable <= 1'b0;
			master_enable_flag <= 1'b0;
		end else if (fault_ev) begin
			port_enable <= 1'b0;
			master_enable_flag <= 1'b0;
		end else if (ctl_write) begin
			port_enable <= ctl_port_enable;
			master_enable_flag <= ctl_master_enable;
		end
	end

	// Flags are sticky; a set in the clearing cycle wins.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			flags <= '0;
		end else begin
			flags.done <= byte_done || (flags.done && !flag_clear.done);
			flags.fault <= fault_ev ||
				(flags.fault && !flag_clear.fault);
			flags.overrun <= (byte_done && !rb_ready) ||
				(flags.overrun && !flag_clear.overrun);
		end
	end

	assign irq = int_enable && (flags.done || flags.fault || flags.overrun);

	// Master sequencer: eight SCK periods, then back to idle.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ssu_pkg::SSU_IDLE;
			div_cnt <= 8'h00;
			sck_out <= 1'b0;
		end else if (fault_ev || !port_enable || !master_enable_flag) begin
			state <= ssu_pkg::SSU_IDLE;
			div_cnt <= 8'h00;
			sck_out <= 1'b0;
		end else begin
			unique case (state)
				ssu_pkg::SSU_IDLE: begin
					div_cnt <= 8'h00;
					sck_out <= 1'b0;
					if (start) begin
						state <= ssu_pkg::SSU_RUN;
					end
				end
				ssu_pkg::SSU_RUN: begin
					if (half_tick) begin
						div_cnt <= 8'h00;
						sck_out <= ~sck_out;
						if (byte_done) begin
							state <= ssu_pkg::SSU_IDLE;
						end
					end else begin
						div_cnt <= div_cnt + 8'h01;
					end
				end
			endcase
		end
	end

	// Shift engine shared by both roles: shift on fall; slave samples on rise, master takes MISO on fall.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			shreg <= 8'h00;
			sample <= 1'b0;
			pend <= 1'b0;
			loaded <= 1'b0;
			bit_cnt <= 4'h0;
		end else if (!port_enable || fault_ev) begin
			pend <= 1'b0;
			loaded <= 1'b0;
			bit_cnt <= 4'h0;
		end else if (!master_enable_flag &&
			select_pin_mode == `SSU_MODE_4WIRE_IN && sel_fall) begin
			pend <= 1'b0;
			bit_cnt <= 4'h0;
			if (tb_pop) begin
				shreg <= tb_data;
				loaded <= 1'b1;
			end
		end else if (tb_pop) begin
			shreg <= tb_data;
			loaded <= 1'b1;
		end else if (byte_done) begin
			bit_cnt <= 4'h0;
			pend <= 1'b0;
			loaded <= 1'b0;
		end else if (rise_ev) begin
			sample <= in_bit;
			pend <= 1'b1;
			bit_cnt <= bit_cnt + 4'h1;
		end else if (fall_ev && pend) begin
			shreg <= {shreg[6:0],
				master_run ? in_bit : sample};
			pend <= 1'b0;
		end
	end

	// Pin drivers per role and select mode.
	assign sck_drv.out = sck_out;
	assign sck_drv.oe = port_enable && master_enable_flag;
	assign mosi_drv.out = shreg[7];
	assign mosi_drv.oe = port_enable && master_enable_flag;
	assign miso_drv.out = shreg[7];
	assign miso_drv.oe = port_enable && !master_enable_flag &&
		selected;
	assign slave_select_drv.out = select_pin_mode[0];
	assign slave_select_drv.oe = select_pin_mode[`SSU_MODE_OUT_BIT];
	assign select_routed = (select_pin_mode != `SSU_MODE_3WIRE);
endmodule : ssu_top

// File: tb/ssu_chk.sv
// Pin and flag assertions for the serial unit.
`timescale 1ns/1ps
module ssu_chk (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [1:0] select_pin_mode,
	input wire logic port_enable,
	input wire logic master_enable_flag,
	input wire ssu_pkg::ssu_flags_t flags,
	input wire logic slave_select_in,
	input wire ssu_pkg::ssu_pin_t sck_drv,
	input wire ssu_pkg::ssu_pin_t mosi_drv,
	input wire ssu_pkg::ssu_pin_t miso_drv,
	input wire ssu_pkg::ssu_pin_t slave_select_drv
);
	logic mst;
	assign mst = port_enable && master_enable_flag;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_sck_dir: assert property (sck_drv.oe == mst)
		else $error("bad sck enable");
	a_mosi_dir: assert property (mosi_drv.oe == mst)
		else $error("bad mosi enable");
	a_miso_off: assert property (
		!port_enable || master_enable_flag |-> !miso_drv.oe)
		else $error("miso driven");
	a_miso_3wire: assert property (
		port_enable && !master_enable_flag && select_pin_mode == 2'h0
		|-> miso_drv.oe) else $error("miso not driven");
	a_miso_unsel: assert property (
		(select_pin_mode == 2'h1 && slave_select_in) [*5]
		|-> !miso_drv.oe) else $error("unselected miso driven");
	a_select_out: assert property (
		slave_select_drv.oe == select_pin_mode[1] && (!select_pin_mode[1]
		|| slave_select_drv.out == select_pin_mode[0]))
		else $error("bad select drive");
	a_sck_high: assert property (
		$rose(sck_drv.out) |-> sck_drv.out [*4] ##1 !sck_drv.out)
		else $error("bad sck high time");
	a_mode_fault: assert property (
		$fell(slave_select_in) && select_pin_mode == 2'h1 && mst
		|-> ##[1:8] !port_enable && !master_enable_flag && flags.fault)
		else $error("no mode fault");
endmodule : ssu_chk
bind ssu_top ssu_chk ssu_chk_inst (.*);

// File: tb/ssu_peer.sv
// Slave on the far side that echoes the previous byte.
`timescale 1ns/1ps
module ssu_peer #(parameter logic [7:0] INIT = 8'h5a) (
	input wire logic sck,
	input wire logic mosi,
	output logic miso
);
	logic [7:0] sh = INIT;
	logic bit_in = 1'b0;
	// Only slave on the bus in three-wire form.
	always @(posedge sck) bit_in <= mosi;
	always @(negedge sck) sh <= {sh[6:0], bit_in};
	assign miso = sh[7];
endmodule : ssu_peer

// File: tb/testbench.sv
// Self-checking bench for the synchronous serial unit.
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] PEER_INIT = 8'h5a;
	logic ref_clk = 1'b0, reset_n = 1'b0, ctl_write = 1'b0;
	logic ctl_port_enable = 1'b0, ctl_master_enable = 1'b0;
	logic int_enable = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
	logic tb_sck = 1'b0, tb_mosi = 1'b0, tb_sel = 1'b1;
	logic [1:0] select_pin_mode = 2'h0;
	logic [7:0] tx_data = 8'h00, sin = 8'h00;
	ssu_pkg::ssu_flags_t flag_clear = '0, flags;
	logic port_enable, master_enable_flag, irq, select_routed;
	logic tx_ready, rx_valid;
	logic [7:0] rx_data;
	ssu_pkg::ssu_pin_t sck_drv, mosi_drv, miso_drv, slave_select_drv;
	wire sck, mosi, miso, sel, peer_miso;
	int seed = 98313, bad_count = 0, n_checks = 0;
	always #20 ref_clk = ~ref_clk;
	assign sck = sck_drv.oe ? sck_drv.out : tb_sck;
	assign mosi = mosi_drv.oe ? mosi_drv.out : tb_mosi;
	assign miso = miso_drv.oe ? miso_drv.out : peer_miso;
	assign sel = slave_select_drv.oe ? slave_select_drv.out : tb_sel;
	ssu_top ssu_top_inst (.ref_clk, .reset_n, .select_pin_mode, .ctl_write,
		.ctl_port_enable, .ctl_master_enable, .int_enable, .flag_clear,
		.port_enable, .master_enable_flag, .flags, .irq, .select_routed,
		.tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
		.sck_in(sck), .sck_drv, .mosi_in(mosi), .mosi_drv, .miso_in(miso),
		.miso_drv, .slave_select_in(sel), .slave_select_drv);
	ssu_peer #(.INIT(PEER_INIT)) ssu_peer_inst (.sck, .mosi,
		.miso(peer_miso));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task ctl(input logic pe, input logic me);
		@(posedge ref_clk);
		ctl_write <= 1'b1;
		ctl_port_enable <= pe;
		ctl_master_enable <= me;
		@(posedge ref_clk);
		ctl_write <= 1'b0;
	endtask : ctl
	task clr(input logic [2:0] m);
		flag_clear <= m;
		@(posedge ref_clk);
		flag_clear <= 3'h0;
		repeat (2) @(posedge ref_clk);
	endtask : clr
	task push(input logic [7:0] d);
		@(posedge ref_clk);
		tx_valid <= 1'b1;
		tx_data <= d;
		do @(posedge ref_clk); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
	endtask : push
	task pop(output logic [7:0] d);
		@(posedge ref_clk);
		rx_ready <= 1'b1;
		do @(posedge ref_clk); while (rx_valid !== 1'b1);
		d = rx_data;
		rx_ready <= 1'b0;
	endtask : pop
	task sbits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			tb_mosi <= b[i];
			repeat (4) @(posedge ref_clk);
			tb_sck <= 1'b1;
			repeat (4) @(posedge ref_clk);
			sin = {sin[6:0], miso};
			tb_sck <= 1'b0;
		end
	endtask : sbits
	function automatic logic routed(input logic [1:0] m);
		return m != 2'h0;
	endfunction : routed
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	initial begin
		#2000000;
		bad_count++;
		end_sim;
	end
	initial begin
		logic [7:0] q[$];
		logic [7:0] d, e;
		logic [2:0] md;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		int_enable <= 1'b1;
		ctl(1'b1, 1'b1);
		for (int i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			q.push_back(d);
			push(d);
		end
		repeat (300) @(posedge ref_clk);
		chk(tx_ready, 1'b0);
		e = PEER_INIT;
		foreach (q[k]) begin
			pop(d);
			chk(d, e);
			e = q[k];
		end
		repeat (8) @(posedge ref_clk);
		chk(ssu_peer_inst.sh, e);
		chk(flags.done, 1'b1);
		chk(irq, 1'b1);
		clr(3'h4);
		chk(flags.done, 1'b0);
		$display("master test done");
		select_pin_mode <= 2'h1;
		ctl(1'b1, 1'b0);
		sbits(8'hc3, 8);
		repeat (10) @(posedge ref_clk);
		chk(rx_valid, 1'b0);
		tb_sel <= 1'b0;
		repeat (10) @(posedge ref_clk);
		sbits(8'ha5, 3);
		tb_sel <= 1'b1;
		push(8'h96);
		repeat (10) @(posedge ref_clk);
		tb_sel <= 1'b0;
		repeat (10) @(posedge ref_clk);
		d = 8'($random(seed));
		sbits(d, 8);
		chk(sin, 8'h96);
		repeat (10) @(posedge ref_clk);
		chk(miso_drv.oe, 1'b1);
		tb_sel <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk(miso_drv.oe, 1'b0);
		pop(e);
		chk(e, d);
		tb_sel <= 1'b0;
		repeat (10) @(posedge ref_clk);
		repeat (3) sbits(8'h3c, 8);
		repeat (10) @(posedge ref_clk);
		chk(flags.overrun, 1'b1);
		pop(e);
		chk(e, 8'h3c);
		tb_sel <= 1'b1;
		select_pin_mode <= 2'h0;
		repeat (3) @(posedge ref_clk);
		chk(miso_drv.oe, 1'b1);
		$display("slave test done");
		select_pin_mode <= 2'h1;
		ctl(1'b1, 1'b1);
		repeat (8) @(posedge ref_clk);
		tb_sel <= 1'b0;
		repeat (12) @(posedge ref_clk);
		chk(port_enable, 1'b0);
		chk(master_enable_flag, 1'b0);
		chk(flags.fault, 1'b1);
		chk(irq, 1'b1);
		tb_sel <= 1'b1;
		clr(3'h2);
		chk(flags.fault, 1'b0);
		repeat (6) @(posedge ref_clk);
		ctl(1'b1, 1'b1);
		for (md = 3'h0; md < 3'h4; md++) begin
			select_pin_mode <= md[1:0];
			repeat (2) @(posedge ref_clk);
			chk(select_routed, routed(md[1:0]));
			chk(slave_select_drv.oe, md[1]);
			if (md[1]) chk(slave_select_drv.out, md[0]);
		end
		$display("mode test done");
		end_sim;
	end
endmodule : testbench
